/* File: ref_select_regs.v */
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ref_sel_map.vh"
// How it works
// - four-bit restore delay, zero to fifteen minutes
// - five revertive bits, one means revertive
// - bit position equals reference index
// - reference zero rank in bits three..zero
// - reference one rank in bits seven..four
// - rank zero highest, larger codes lower
// - auto mode switches on failure, else holdover
// - manual mode: select codes zero..four, rest reserved
// - only unmasked failure indicators count
module ref_select_regs #(
    parameter        NUM_REFS      = 5,
    parameter        NUM_IND       = 4,
    parameter        ADDR_W        = 10,
    parameter [31:0] MINUTE_CYCLES = `RS_MINUTE_CYCLES
) (
    // ahb-lite slave
    input  wire                      hclk,
    input  wire                      hresetn,
    input  wire                      hsel,
    input  wire [ADDR_W-1:0]         haddr,
    input  wire [1:0]                htrans,
    input  wire                      hwrite,
    input  wire [2:0]                hsize,
    input  wire [31:0]               hwdata,
    input  wire                      hready,
    output reg  [31:0]               hrdata,
    output reg                       hreadyout,
    output reg                       hresp,
    // reference monitors, four indicators per reference
    input  wire [NUM_REFS*NUM_IND-1:0] ref_fail_flags,
    // selection result
    output reg  [2:0]                active_ref,
    output reg                       holdover,
    output reg                       freerun,
    output reg  [NUM_REFS-1:0]       ref_qualified
);
    // ****************************************
    // registers
    // ****************************************
    reg  [1:0]          mode_sel;                 // loop mode
    reg  [3:0]          manual_sel;               // manual reference code
    reg  [3:0]          switchover_fail_mask;     // counted indicators
    reg  [3:0]          fault_free_delay_minutes; // restore delay
    reg  [4:0]          revert_enable;            // one bit per reference
    reg  [7:0]          rank_low;                 // ranks of refs 0 and 1
    reg  [7:0]          rank_mid;                 // ranks of refs 2 and 3
    reg  [3:0]          rank_high;                // rank of ref 4
    reg  [1:0]          next_mode_sel;
    reg  [3:0]          next_manual_sel;
    reg  [3:0]          next_fail_mask;
    reg  [3:0]          next_delay;
    reg  [4:0]          next_revert;
    reg  [7:0]          next_rank_low;
    reg  [7:0]          next_rank_mid;
    reg  [3:0]          next_rank_high;

    // ****************************************
    // bus address phase capture
    // ****************************************
    reg                 wr_pending;  // write in data phase
    reg  [7:0]          wr_index;    // its register index
    wire                addr_take;   // valid address phase
    wire [7:0]          rd_index;    // index of current address phase
    wire                word_ok;     // aligned word-size transfer

    assign addr_take = hsel & htrans[1] & hready;
    assign word_ok   = (haddr[1:0] == 2'b00) && (hsize == 3'b010);
    assign rd_index  = haddr[9:2];

    // hold write address until its data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_index   <= 8'h00;
        end else if (hready) begin
            wr_pending <= addr_take & hwrite & word_ok;
            wr_index   <= rd_index;
        end
    end

    // ****************************************
    // register write decode
    // ****************************************
    wire wr_now = wr_pending;  // data phase always completes, no wait states

    // next values; reads see these, so write-then-read is coherent
    always @* begin
        next_mode_sel   = mode_sel;
        next_manual_sel = manual_sel;
        next_fail_mask  = switchover_fail_mask;
        next_delay      = fault_free_delay_minutes;
        next_revert     = revert_enable;
        next_rank_low   = rank_low;
        next_rank_mid   = rank_mid;
        next_rank_high  = rank_high;
        if (wr_now) begin
            case (wr_index)
                `RS_IDX_MODE:       next_mode_sel  = hwdata[1:0];
                `RS_IDX_MANUAL_SEL: begin
                    // writable only in manual mode; codes above four reserved
                    if (mode_sel == `RS_MODE_MANUAL && hwdata[3:0] <= 4'h4) begin
                        next_manual_sel = hwdata[3:0];
                    end
                end
                `RS_IDX_FAIL_MASK:  next_fail_mask = hwdata[3:0];
                `RS_IDX_RESTORE:    next_delay     = hwdata[3:0];
                `RS_IDX_REVERT:     next_revert    = hwdata[4:0];
                `RS_IDX_RANK_LOW:   next_rank_low  = hwdata[7:0];
                `RS_IDX_RANK_MID:   next_rank_mid  = hwdata[7:0];
                `RS_IDX_RANK_HIGH:  next_rank_high = hwdata[3:0];
                default:            next_mode_sel  = mode_sel;     // unmapped: ignored
            endcase
        end
    end

    // register storage
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_sel                 <= `RS_RST_MODE;
            manual_sel               <= `RS_RST_MANUAL_SEL;
            switchover_fail_mask     <= `RS_RST_FAIL_MASK;
            fault_free_delay_minutes <= `RS_RST_RESTORE;
            revert_enable            <= `RS_RST_REVERT;
            rank_low                 <= `RS_RST_RANK_LOW;
            rank_mid                 <= `RS_RST_RANK_MID;
            rank_high                <= `RS_RST_RANK_HIGH;
        end else begin
            mode_sel                 <= next_mode_sel;
            manual_sel               <= next_manual_sel;
            switchover_fail_mask     <= next_fail_mask;
            fault_free_delay_minutes <= next_delay;
            revert_enable            <= next_revert;
            rank_low                 <= next_rank_low;
            rank_mid                 <= next_rank_mid;
            rank_high                <= next_rank_high;
        end
    end

    // ****************************************
    // read mux, registered into the data phase
    // ****************************************
    reg [31:0] rd_value;  // word for current address phase

    always @* begin
        rd_value = 32'h0000_0000;  // unmapped and reserved bits read zero
        case (rd_index)
            `RS_IDX_MODE:       rd_value[1:0] = next_mode_sel;
            `RS_IDX_MANUAL_SEL: begin
                // auto mode shows the live choice instead of the stored code
                if (mode_sel == `RS_MODE_AUTO) begin
                    rd_value[2:0] = active_ref;
                end else begin
                    rd_value[3:0] = next_manual_sel;
                end
            end
            `RS_IDX_FAIL_MASK:  rd_value[3:0] = next_fail_mask;
            `RS_IDX_RESTORE:    rd_value[3:0] = next_delay;
            `RS_IDX_REVERT:     rd_value[4:0] = next_revert;
            `RS_IDX_RANK_LOW:   rd_value[7:0] = next_rank_low;
            `RS_IDX_RANK_MID:   rd_value[7:0] = next_rank_mid;
            `RS_IDX_RANK_HIGH:  rd_value[3:0] = next_rank_high;
            `RS_IDX_STATUS:     rd_value[9:0] = {ref_qualified, freerun, holdover,
                                                 active_ref};
            default:            rd_value = 32'h0000_0000;
        endcase
    end

    // data phase outputs; zero wait states, always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_take && !hwrite && word_ok) begin
                hrdata <= rd_value;
            end
        end
    end

    // ****************************************
    // per-reference qualification
    // ****************************************
    wire [NUM_REFS-1:0] ref_fault;     // an unmasked indicator is set
    wire [NUM_REFS-1:0] ref_eligible;  // restore delay has run out
    wire [NUM_REFS-1:0] qual_now;      // usable right now
    wire [4*NUM_REFS-1:0] rank_vec;    // ranks, ref i at [4i+3:4i]

    assign rank_vec = {rank_high, rank_mid, rank_low};

    genvar g;
    generate
        for (g = 0; g < NUM_REFS; g = g + 1) begin : gen_ref
            // masked indicators never count as failure
            assign ref_fault[g] = |(ref_fail_flags[g*NUM_IND +: NUM_IND]
                                    & switchover_fail_mask);
            restore_timer #(
                .MINUTE_CYCLES (MINUTE_CYCLES)
            ) u_timer (
                .hclk          (hclk),
                .hresetn       (hresetn),
                .fault         (ref_fault[g]),
                .delay_minutes (fault_free_delay_minutes),
                .eligible      (ref_eligible[g])
            );
            assign qual_now[g] = ref_eligible[g] & ~ref_fault[g];
        end
    endgenerate

    // ****************************************
    // best qualified reference by rank
    // ****************************************
    reg [2:0] best_ref;    // highest ranked qualified reference
    reg       best_found;  // at least one qualified
    reg [3:0] best_rank;   // its rank code
    integer   i;

    // strict compare: equal ranks keep the lower index
    always @* begin
        best_ref   = 3'h0;
        best_found = 1'b0;
        best_rank  = 4'hf;
        for (i = 0; i < NUM_REFS; i = i + 1) begin
            if (qual_now[i] && (!best_found || rank_vec[4*i +: 4] < best_rank)) begin
                best_ref   = i[2:0];
                best_found = 1'b1;
                best_rank  = rank_vec[4*i +: 4];
            end
        end
    end

    wire [3:0] cur_rank = rank_vec[4*active_ref +: 4];
    wire       cur_ok   = !holdover && qual_now[active_ref];

    // ****************************************
    // selection state
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_ref    <= 3'h0;
            holdover      <= 1'b1;  // nothing locked until a reference qualifies
            freerun       <= 1'b0;
            ref_qualified <= {NUM_REFS{1'b0}};
        end else begin
            ref_qualified <= qual_now;
            freerun       <= (mode_sel == `RS_MODE_FREERUN);
            case (mode_sel)
                `RS_MODE_AUTO: begin
                    if (cur_ok) begin
                        // better reference back: revert only if marked so
                        if (best_found && best_rank < cur_rank
                            && revert_enable[best_ref]) begin
                            active_ref <= best_ref;
                        end
                    end else if (best_found) begin
                        active_ref <= best_ref;
                        holdover   <= 1'b0;
                    end else begin
                        holdover   <= 1'b1;
                    end
                end
                `RS_MODE_MANUAL: begin
                    active_ref <= manual_sel[2:0];
                    holdover   <= ref_fault[manual_sel[2:0]];
                end
                `RS_MODE_HOLDOVER: holdover <= 1'b1;
                `RS_MODE_FREERUN:  holdover <= 1'b0;
                default:           holdover <= 1'b1;
            endcase
        end
    end
endmodule // ref_select_regs

/* File: ref_sel_map.vh */
`ifndef REF_SEL_MAP_VH
`define REF_SEL_MAP_VH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define RS_IDX_MODE        8'h1f
`define RS_IDX_MANUAL_SEL  8'h2d
`define RS_IDX_FAIL_MASK   8'h2e
`define RS_IDX_RESTORE     8'h2f
`define RS_IDX_REVERT      8'h30
`define RS_IDX_RANK_LOW    8'h31
`define RS_IDX_RANK_MID    8'h32
`define RS_IDX_RANK_HIGH   8'h33
`define RS_IDX_STATUS      8'h3f

// ****************************************
// reset values
// ****************************************
`define RS_RST_MODE        2'h0
`define RS_RST_MANUAL_SEL  4'h0
`define RS_RST_FAIL_MASK   4'hc
`define RS_RST_RESTORE     4'h0
`define RS_RST_REVERT      5'h00
`define RS_RST_RANK_LOW    8'h10
`define RS_RST_RANK_MID    8'h32
`define RS_RST_RANK_HIGH   4'h4

// ****************************************
// field positions
// ****************************************
`define RS_RANK_LO_MSB     3
`define RS_RANK_LO_LSB     0
`define RS_RANK_HI_MSB     7
`define RS_RANK_HI_LSB     4

// ****************************************
// mode codes
// ****************************************
`define RS_MODE_MANUAL     2'h0
`define RS_MODE_HOLDOVER   2'h1
`define RS_MODE_FREERUN    2'h2
`define RS_MODE_AUTO       2'h3

// ****************************************
// timing: one minute at the 50 MHz clock
// ****************************************
`define RS_CLK_HZ          32'd50000000
`define RS_MINUTE_S        32'd60
`define RS_MINUTE_CYCLES   (`RS_CLK_HZ * `RS_MINUTE_S)

`endif

/* File: restore_timer.v */
`timescale 1ns/1ps
// ****************************************
// restore delay timer for one reference
// ****************************************
module restore_timer #(
    parameter [31:0] MINUTE_CYCLES = 32'd3000000000
) (
    // clock and reset
    input  wire       hclk,
    input  wire       hresetn,
    // reference condition
    input  wire       fault,         // unmasked failure present
    input  wire [3:0] delay_minutes, // fault-free wait
    // result
    output reg        eligible       // usable for selection
);
    reg [31:0] cycle_cnt;   // cycles inside current minute
    reg [3:0]  minute_cnt;  // whole minutes fault free

    // restart on any fault, count whole fault-free minutes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eligible   <= 1'b1;  // no earlier failure at reset
            cycle_cnt  <= 32'h0000_0000;
            minute_cnt <= 4'h0;
        end else if (fault) begin
            eligible   <= 1'b0;
            cycle_cnt  <= 32'h0000_0000;
            minute_cnt <= 4'h0;
        end else if (!eligible) begin
            if (minute_cnt >= delay_minutes) begin
                eligible <= 1'b1;
            end else if (cycle_cnt == MINUTE_CYCLES - 32'd1) begin
                // full minute only: a partial minute never counts
                cycle_cnt  <= 32'h0000_0000;
                minute_cnt <= minute_cnt + 4'h1;
            end else begin
                cycle_cnt <= cycle_cnt + 32'h0000_0001;
            end
        end
    end
endmodule // restore_timer

/* File: ref_sel_chk.sv */
`timescale 1ns/1ps
`include "ref_sel_map.vh"
// ****************************************
// bus and selection checker
// ****************************************
module ref_sel_chk #(
    parameter NUM_REFS = 5,
    parameter NUM_IND  = 4,
    parameter ADDR_W   = 10
) (
    // bus side
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         hsel,
    input wire logic [ADDR_W-1:0]            haddr,
    input wire logic [1:0]                   htrans,
    input wire logic                         hwrite,
    input wire logic [2:0]                   hsize,
    input wire logic [31:0]                  hwdata,
    input wire logic                         hready,
    input wire logic [31:0]                  hrdata,
    input wire logic                         hreadyout,
    input wire logic                         hresp,
    // monitors and selection
    input wire logic [NUM_REFS*NUM_IND-1:0]  ref_fail_flags,
    input wire logic [2:0]                   active_ref,
    input wire logic                         holdover,
    input wire logic                         freerun,
    input wire logic [NUM_REFS-1:0]          ref_qualified
);
    // aligned word read taken at this edge
    wire       rd_take = hsel && htrans[1] && !hwrite && hready && hsize == 3'h2 && haddr[1:0] == 2'h0;
    wire [7:0] idx     = haddr[9:2];         // register index
    // ref zero fault on indicators the reset mask keeps
    wire       f0      = |ref_fail_flags[3:2];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_never_wait: assert property (hreadyout) else $error("slave stalled");
    a_delay_width: assert property (rd_take && idx == `RS_IDX_RESTORE |=> hrdata[31:4] == 28'h0)
        else $error("restore delay wider than four bits");
    a_revert_width: assert property (rd_take && idx == `RS_IDX_REVERT |=> hrdata[31:5] == 27'h0)
        else $error("revert enable wider than five bits");
    a_rank_width: assert property (rd_take && idx == `RS_IDX_RANK_LOW |=> hrdata[31:8] == 24'h0)
        else $error("rank pair wider than eight bits");
    a_read_hold: assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved");
    a_fault_unqual: assert property (f0 |=> !ref_qualified[0])
        else $error("faulty ref zero still qualified");
    a_fault_leave: assert property (f0 && active_ref == 3'h0 && !holdover && !freerun
        |-> ##[1:2] (active_ref != 3'h0 || holdover)) else $error("kept failed ref");
    a_ref_range: assert property (active_ref <= 3'h4) else $error("active ref out of range");

    c_read: cover property (rd_take);
    c_holdover: cover property ($rose(holdover));
    c_switch: cover property ($changed(active_ref));
    c_freerun: cover property ($rose(freerun));
endmodule // ref_sel_chk

bind ref_select_regs ref_sel_chk #(.NUM_REFS(NUM_REFS), .NUM_IND(NUM_IND), .ADDR_W(ADDR_W)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ref_fail_flags(ref_fail_flags),
    .active_ref(active_ref), .holdover(holdover), .freerun(freerun),
    .ref_qualified(ref_qualified));

/* File: testbench.sv */
`timescale 1ns/1ps
`include "ref_sel_map.vh"
module testbench;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        hclk, hresetn, hsel, hwrite;
    logic [9:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, rd;
    logic [19:0] ref_fail_flags;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, holdover, freerun;
    wire  [2:0]  active_ref;
    wire  [4:0]  ref_qualified;
    wire         hready = hreadyout;   // single slave drives bus ready
    int          err_total, samples_checked;
    // table rows: index, write value, read-back value
    typedef struct { logic [7:0] idx; logic [31:0] wd; logic [31:0] ex; } row_t;
    row_t rows[9] = '{'{`RS_IDX_RESTORE, 32'hff, 32'hf}, '{`RS_IDX_RESTORE, 32'hf2, 32'h2},
        '{`RS_IDX_REVERT, 32'hff, 32'h1f}, '{`RS_IDX_REVERT, 32'he0, 32'h0},
        '{`RS_IDX_RANK_LOW, 32'ha5, 32'ha5}, '{`RS_IDX_RANK_LOW, 32'h10, 32'h10},
        '{`RS_IDX_FAIL_MASK, 32'hf3, 32'h3}, '{`RS_IDX_FAIL_MASK, 32'h0c, 32'hc},
        '{8'h20, 32'hff, 32'h0}};

    // short minute keeps restore waits at tens of cycles
    ref_select_regs #(.MINUTE_CYCLES(32'd10)) ref_select_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ref_fail_flags(ref_fail_flags),
        .active_ref(active_ref), .holdover(holdover), .freerun(freerun),
        .ref_qualified(ref_qualified));

    // ****************************************
    // helper tasks
    // ****************************************
    // one single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // register value compare
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // selection compare; ref ignored while in holdover
    task automatic chk_sel(input logic h, input logic [2:0] r);
        chk_reg({28'h0, holdover, holdover ? 3'h0 : active_ref}, {28'h0, h, r});
    endtask
    // sample away from the launching edge
    task automatic settle(input int n);
        repeat (n) @(negedge hclk);
    endtask
    task automatic setf(input logic [19:0] v);
        @(posedge hclk);
        ref_fail_flags <= v;
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, main sequence
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        give_verdict;
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, ref_fail_flags} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 32'h0);
            chk_reg(rd, rows[i].ex);
        end
        $display("register table done");
        bus(1'b1, `RS_IDX_MODE, 32'h3);
        setf(20'h00001); settle(4); chk_sel(1'b0, 3'h0);
        setf(20'h00004); settle(4); chk_sel(1'b0, 3'h1);
        setf(20'h0); settle(40); chk_sel(1'b0, 3'h1);
        bus(1'b1, `RS_IDX_REVERT, 32'h1); settle(4); chk_sel(1'b0, 3'h0);
        setf(20'h00004); settle(4); chk_sel(1'b0, 3'h1);
        setf(20'h0); settle(15); chk_sel(1'b0, 3'h1);
        settle(14); chk_sel(1'b0, 3'h0);
        bus(1'b1, `RS_IDX_RANK_LOW, 32'h01); settle(4); chk_sel(1'b0, 3'h0);
        bus(1'b1, `RS_IDX_REVERT, 32'h2); settle(4); chk_sel(1'b0, 3'h1);
        bus(1'b0, `RS_IDX_MANUAL_SEL, 32'h0); chk_reg(rd, 32'h1);
        setf(20'hccccc); settle(4); chk_sel(1'b1, 3'h0);
        bus(1'b0, `RS_IDX_STATUS, 32'h0); chk_reg(rd, 32'h9);
        $display("automatic selection done");
        setf(20'h0);
        bus(1'b1, `RS_IDX_MODE, 32'h0);
        bus(1'b1, `RS_IDX_MANUAL_SEL, 32'h2); settle(4); chk_sel(1'b0, 3'h2);
        bus(1'b1, `RS_IDX_MANUAL_SEL, 32'h5); settle(4); chk_sel(1'b0, 3'h2);
        $display("manual selection done");
        // fixed modes: freerun flag, then forced holdover
        bus(1'b1, `RS_IDX_MODE, 32'h2); settle(4); chk_reg({31'h0, freerun}, 32'h1);
        chk_sel(1'b0, 3'h2);
        bus(1'b1, `RS_IDX_MODE, 32'h1); settle(4); chk_reg({31'h0, freerun}, 32'h0);
        chk_sel(1'b1, 3'h0);
        $display("fixed modes done");
        // second reset in mid-run restores defaults
        @(posedge hclk);
        hresetn <= 1'b0;
        settle(2); chk_sel(1'b1, 3'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `RS_IDX_RESTORE, 32'h0); chk_reg(rd, 32'h0);
        bus(1'b0, `RS_IDX_REVERT, 32'h0); chk_reg(rd, 32'h0);
        bus(1'b0, `RS_IDX_RANK_LOW, 32'h0); chk_reg(rd, 32'h10);
        bus(1'b0, `RS_IDX_STATUS, 32'h0); chk_reg(rd, 32'h3e0);
        $display("reset values done");
        give_verdict;
    end
endmodule // testbench
